// ---- uhi_pkg.sv ----
// Constants for the host controller event and list-pointer block
// Summary of operation
// - Ownership change request sets ownership status; enabled, it raises management interrupt at once.
// - Without a management interrupt pin the ownership status bit always reads zero.
// - Any root hub or downstream port state change sets the root hub change bit.
// - Frame number top bit toggling, after shared copy update, sets frame overflow bit.
// - System error sets unrecoverable bit and halts processing; software clears after reset.
// - Resume bit sets on rising device resume signalling, not on software resume state.
// - At frame start, after shared update, set start-of-frame bit and emit token together; while halted the bit sets but the token is withheld.
// - Set done-head bit after writeback; no further writeback until software clears it.
// - Schedule overrun sets overrun bit after frame update and increments overrun counter.
// - Host interrupt only when status bit, its enable and master enable are all set.
// - Enable register write sets bits written one; read returns current enable value.
// - Disable register write clears enable bits written one; read returns enable value.
// - Master enable resets to one, following the description over the printed zero.
// - Communication base low eight bits read zero, giving 256-byte alignment.
// - Periodic current pointer updates after each periodic descriptor; readable any time.
// - Control head pointer holds a 28-bit descriptor address, low bits reserved.
// - Pointer partition is seven 32-bit registers at base 0x1000 plus offset.
// - Status bits clear only by software writing one; hardware never clears them.
// - Two-bit overrun counter starts at zero, wraps, increments even if bit already set.
package uhi_pkg;

	localparam int ADDR_W = 16;

	// Register byte addresses
	localparam logic [15:0] OFF_CMD_STATUS  = 16'h1008;
	localparam logic [15:0] OFF_EVT_STATUS  = 16'h100c;
	localparam logic [15:0] OFF_EN_SET      = 16'h1010;
	localparam logic [15:0] OFF_EN_CLEAR    = 16'h1014;
	localparam logic [15:0] OFF_COMM_BASE   = 16'h1018;
	localparam logic [15:0] OFF_PERIOD_CUR  = 16'h101c;
	localparam logic [15:0] OFF_CTRL_HEAD   = 16'h1020;
	localparam logic [15:0] OFF_CTRL_CUR    = 16'h1024;
	localparam logic [15:0] OFF_BULK_HEAD   = 16'h1028;
	localparam logic [15:0] OFF_BULK_CUR    = 16'h102c;
	localparam logic [15:0] OFF_DONE_HEAD   = 16'h1030;

	// Event bit positions (shared by status and enable, except master bit 31 in enable only)
	localparam int BIT_MASTER   = 31;
	localparam int BIT_OWNER    = 30;
	localparam int BIT_ROOTHUB  = 6;
	localparam int BIT_FRAMEOVF = 5;
	localparam int BIT_UNRECOV  = 4;
	localparam int BIT_RESUME   = 3;
	localparam int BIT_SOF      = 2;
	localparam int BIT_DONEHEAD = 1;
	localparam int BIT_OVERRUN  = 0;

	// Command status fields
	localparam int BIT_OWN_REQ  = 3;
	localparam int OVR_CNT_LSB  = 16;
	localparam int OVR_CNT_W    = 2;

	// Writable masks
	localparam logic [31:0] EVT_MASK     = 32'h4000_007f;
	localparam logic [31:0] EN_MASK      = 32'hc000_007f;
	localparam logic [31:0] COMM_MASK    = 32'hffff_ff00;
	localparam logic [31:0] PTR_MASK     = 32'hffff_fff0;

	// Values after reset
	localparam logic [31:0] EVT_RST      = 32'h0000_0000;
	localparam logic [31:0] EN_RST       = 32'h8000_0000;
	localparam logic [31:0] PTR_RST      = 32'h0000_0000;
	localparam logic [1:0]  OVR_CNT_RST  = 2'h0;

endpackage

// ---- uhi_irq_ptr.sv ----
// Event status, interrupt enables and list pointers behind an APB slave
module uhi_irq_ptr #(
	parameter bit HAS_MGMT_PIN = 1'b1
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Controller core events
	input  wire logic        rootHubChange,
	input  wire logic        frameNumberTop,
	input  wire logic        sharedFrameWritten,
	input  wire logic        scheduleOverrun,
	input  wire logic        systemError,
	input  wire logic        resumeStateSelected,
	input  wire logic        ownershipDone,
	// Done queue
	input  wire logic        transferDone,
	input  wire logic [31:0] transferAddr,
	input  wire logic        sharedDonePointerWritten,
	output logic             doneWritebackAllowed,
	// Periodic list progress
	input  wire logic        periodicDescDone,
	input  wire logic [31:0] periodicDescAddr,
	// Downstream resume signalling pin
	input  wire logic        resumeSignal,
	// Results
	output logic             hostIrq,
	output logic             systemManagementIrq,
	output logic             startOfFrameToken,
	output logic             processingHalted,
	output logic [31:0]      commAreaBase,
	output logic [31:0]      controlListHead,
	output logic [31:0]      controlListCurrent,
	output logic [31:0]      bulkListHead,
	output logic [31:0]      bulkListCurrent,
	output logic [31:0]      lastDoneTransfer
);

	// Register state
	logic [31:0] evtStatus_q;
	logic [31:0] evtStatus_d;
	logic [31:0] irqEnable_q;
	logic [31:0] irqEnable_d;
	logic        ownReq_q;
	logic [1:0]  ovrCount_q;
	logic [31:0] commBase_q;
	logic [31:0] periodCur_q;
	logic [31:0] ctrlHead_q;
	logic [31:0] ctrlCur_q;
	logic [31:0] bulkHead_q;
	logic [31:0] bulkCur_q;
	logic [31:0] doneHead_q;
	logic [31:0] rdata_q;
	logic        frameTop_q;
	logic        resumeMeta_q;
	logic        resumeSync_q;
	logic        resumeLast_q;

	logic        setupPhase;
	logic        wrStrobe;
	logic [31:0] wMask;
	logic [31:0] wBits;
	logic [31:0] evtSet;
	logic [31:0] evtClr;
	logic        resumeRise;
	logic        ownerLive;
	logic [31:0] rdMux;
	logic        wrCmd;
	logic        wrEvt;
	logic        wrEnSet;
	logic        wrEnClr;
	logic        wrComm;
	logic        wrCtrlHead;
	logic        wrCtrlCur;
	logic        wrBulkHead;
	logic        wrBulkCur;

	// Byte-lane mask from write strobes
	function automatic logic [31:0] laneMask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// Address hit on a given register
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		return a == off;
	endfunction

	// Known register offset
	function automatic logic mapped(input logic [15:0] a);
		return hit(a, uhi_pkg::OFF_CMD_STATUS) || hit(a, uhi_pkg::OFF_EVT_STATUS)
			|| hit(a, uhi_pkg::OFF_EN_SET) || hit(a, uhi_pkg::OFF_EN_CLEAR)
			|| hit(a, uhi_pkg::OFF_COMM_BASE) || hit(a, uhi_pkg::OFF_PERIOD_CUR)
			|| hit(a, uhi_pkg::OFF_CTRL_HEAD) || hit(a, uhi_pkg::OFF_CTRL_CUR)
			|| hit(a, uhi_pkg::OFF_BULK_HEAD) || hit(a, uhi_pkg::OFF_BULK_CUR)
			|| hit(a, uhi_pkg::OFF_DONE_HEAD);
	endfunction

	// Bus handshake: zero wait states
	assign setupPhase = psel && !penable;
	assign pready     = psel && penable;
	assign pslverr    = psel && penable && !mapped(paddr);
	assign wrStrobe   = psel && penable && pwrite;
	assign wMask      = laneMask(pstrb);
	assign wBits      = pwdata & wMask;
	assign prdata     = rdata_q;

	// Per-register write decode
	assign wrCmd      = wrStrobe && hit(paddr, uhi_pkg::OFF_CMD_STATUS);
	assign wrEvt      = wrStrobe && hit(paddr, uhi_pkg::OFF_EVT_STATUS);
	assign wrEnSet    = wrStrobe && hit(paddr, uhi_pkg::OFF_EN_SET);
	assign wrEnClr    = wrStrobe && hit(paddr, uhi_pkg::OFF_EN_CLEAR);
	assign wrComm     = wrStrobe && hit(paddr, uhi_pkg::OFF_COMM_BASE);
	assign wrCtrlHead = wrStrobe && hit(paddr, uhi_pkg::OFF_CTRL_HEAD);
	assign wrCtrlCur  = wrStrobe && hit(paddr, uhi_pkg::OFF_CTRL_CUR);
	assign wrBulkHead = wrStrobe && hit(paddr, uhi_pkg::OFF_BULK_HEAD);
	assign wrBulkCur  = wrStrobe && hit(paddr, uhi_pkg::OFF_BULK_CUR);

	// Resume pin synchroniser
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			resumeMeta_q <= 1'b0;
			resumeSync_q <= 1'b0;
			resumeLast_q <= 1'b0;
		end else begin
			resumeMeta_q <= resumeSignal;
			resumeSync_q <= resumeMeta_q;
			resumeLast_q <= resumeSync_q;
		end
	end

	assign resumeRise = resumeSync_q && !resumeLast_q && !resumeStateSelected;

	// Frame number top bit tracker, sampled at shared copy update
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			frameTop_q <= 1'b0;
		end else if (sharedFrameWritten) begin
			frameTop_q <= frameNumberTop;
		end
	end

	assign ownerLive = HAS_MGMT_PIN && ownReq_q;

	// Event sources
	always_comb begin
		evtSet = '0;
		evtSet[uhi_pkg::BIT_OWNER]    = ownerLive;
		evtSet[uhi_pkg::BIT_ROOTHUB]  = rootHubChange;
		evtSet[uhi_pkg::BIT_FRAMEOVF] = sharedFrameWritten && (frameNumberTop != frameTop_q);
		evtSet[uhi_pkg::BIT_UNRECOV]  = systemError;
		evtSet[uhi_pkg::BIT_RESUME]   = resumeRise;
		evtSet[uhi_pkg::BIT_SOF]      = sharedFrameWritten;
		evtSet[uhi_pkg::BIT_DONEHEAD] = sharedDonePointerWritten && !evtStatus_q[uhi_pkg::BIT_DONEHEAD];
		evtSet[uhi_pkg::BIT_OVERRUN]  = scheduleOverrun && sharedFrameWritten;
	end

	// Write-one-to-clear, set wins over clear
	assign evtClr = wrEvt ? wBits : '0;

	always_comb begin
		evtStatus_d = ((evtStatus_q & ~evtClr) | evtSet) & uhi_pkg::EVT_MASK;
		if (!HAS_MGMT_PIN) begin
			evtStatus_d[uhi_pkg::BIT_OWNER] = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			evtStatus_q <= uhi_pkg::EVT_RST;
		end else begin
			evtStatus_q <= evtStatus_d;
		end
	end

	// Enable register with set and clear aliases
	always_comb begin
		irqEnable_d = irqEnable_q;
		if (wrEnSet) begin
			irqEnable_d = irqEnable_q | (wBits & uhi_pkg::EN_MASK);
		end else if (wrEnClr) begin
			irqEnable_d = irqEnable_q & ~(wBits & uhi_pkg::EN_MASK);
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irqEnable_q <= uhi_pkg::EN_RST;
		end else begin
			irqEnable_q <= irqEnable_d;
		end
	end

	// Ownership request
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ownReq_q <= 1'b0;
		end else if (wrCmd && wBits[uhi_pkg::BIT_OWN_REQ]) begin
			ownReq_q <= 1'b1;
		end else if (ownershipDone) begin
			ownReq_q <= 1'b0;
		end
	end

	// Overrun counter
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ovrCount_q <= uhi_pkg::OVR_CNT_RST;
		end else if (evtSet[uhi_pkg::BIT_OVERRUN]) begin
			ovrCount_q <= ovrCount_q + 2'h1;
		end
	end

	// Communication base
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			commBase_q <= uhi_pkg::PTR_RST;
		end else if (wrComm) begin
			commBase_q <= ((commBase_q & ~wMask) | wBits) & uhi_pkg::COMM_MASK;
		end
	end

	// Periodic current pointer, hardware owned
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			periodCur_q <= uhi_pkg::PTR_RST;
		end else if (periodicDescDone) begin
			periodCur_q <= periodicDescAddr & uhi_pkg::PTR_MASK;
		end
	end

	// Control list head
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctrlHead_q <= uhi_pkg::PTR_RST;
		end else if (wrCtrlHead) begin
			ctrlHead_q <= ((ctrlHead_q & ~wMask) | wBits) & uhi_pkg::PTR_MASK;
		end
	end

	// Control list current
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctrlCur_q <= uhi_pkg::PTR_RST;
		end else if (wrCtrlCur) begin
			ctrlCur_q <= ((ctrlCur_q & ~wMask) | wBits) & uhi_pkg::PTR_MASK;
		end
	end

	// Bulk list head
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bulkHead_q <= uhi_pkg::PTR_RST;
		end else if (wrBulkHead) begin
			bulkHead_q <= ((bulkHead_q & ~wMask) | wBits) & uhi_pkg::PTR_MASK;
		end
	end

	// Bulk list current
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bulkCur_q <= uhi_pkg::PTR_RST;
		end else if (wrBulkCur) begin
			bulkCur_q <= ((bulkCur_q & ~wMask) | wBits) & uhi_pkg::PTR_MASK;
		end
	end

	// Done head: loaded per finished transfer, zeroed on writeback
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			doneHead_q <= uhi_pkg::PTR_RST;
		end else if (evtSet[uhi_pkg::BIT_DONEHEAD]) begin
			doneHead_q <= uhi_pkg::PTR_RST;
		end else if (transferDone) begin
			doneHead_q <= transferAddr & uhi_pkg::PTR_MASK;
		end
	end

	// Read multiplexer
	always_comb begin
		rdMux = '0;
		unique case (1'b1)
			hit(paddr, uhi_pkg::OFF_CMD_STATUS): begin
				rdMux[uhi_pkg::OVR_CNT_LSB +: uhi_pkg::OVR_CNT_W] = ovrCount_q;
				rdMux[uhi_pkg::BIT_OWN_REQ] = ownReq_q;
			end
			hit(paddr, uhi_pkg::OFF_EVT_STATUS): rdMux = evtStatus_q;
			hit(paddr, uhi_pkg::OFF_EN_SET):     rdMux = irqEnable_q;
			hit(paddr, uhi_pkg::OFF_EN_CLEAR):   rdMux = irqEnable_q;
			hit(paddr, uhi_pkg::OFF_COMM_BASE):  rdMux = commBase_q;
			hit(paddr, uhi_pkg::OFF_PERIOD_CUR): rdMux = periodCur_q;
			hit(paddr, uhi_pkg::OFF_CTRL_HEAD):  rdMux = ctrlHead_q;
			hit(paddr, uhi_pkg::OFF_CTRL_CUR):   rdMux = ctrlCur_q;
			hit(paddr, uhi_pkg::OFF_BULK_HEAD):  rdMux = bulkHead_q;
			hit(paddr, uhi_pkg::OFF_BULK_CUR):   rdMux = bulkCur_q;
			hit(paddr, uhi_pkg::OFF_DONE_HEAD):  rdMux = doneHead_q;
			default:                             rdMux = '0;
		endcase
	end

	// Read data captured in setup phase
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rdata_q <= '0;
		end else if (setupPhase && !pwrite) begin
			rdata_q <= rdMux;
		end
	end

	// Interrupt outputs
	assign hostIrq = irqEnable_q[uhi_pkg::BIT_MASTER]
		&& |(evtStatus_q & irqEnable_q & uhi_pkg::EVT_MASK);
	assign systemManagementIrq = evtStatus_q[uhi_pkg::BIT_OWNER]
		&& irqEnable_q[uhi_pkg::BIT_OWNER];

	// Core-facing outputs
	// Token withheld while halted
	assign startOfFrameToken    = evtSet[uhi_pkg::BIT_SOF]
		&& !evtStatus_q[uhi_pkg::BIT_UNRECOV];
	assign processingHalted     = evtStatus_q[uhi_pkg::BIT_UNRECOV];
	assign doneWritebackAllowed = !evtStatus_q[uhi_pkg::BIT_DONEHEAD];
	assign commAreaBase         = commBase_q;
	assign controlListHead      = ctrlHead_q;
	assign controlListCurrent   = ctrlCur_q;
	assign bulkListHead         = bulkHead_q;
	assign bulkListCurrent      = bulkCur_q;
	assign lastDoneTransfer     = doneHead_q;

endmodule // uhi_irq_ptr

// ---- uhi_irq_ptr_chk.sv ----
// Port checker for the event and list-pointer block
module uhi_irq_ptr_chk (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	// Events and results
	input wire logic        sharedFrameWritten,
	input wire logic        systemError,
	input wire logic        sharedDonePointerWritten,
	input wire logic        doneWritebackAllowed,
	input wire logic        startOfFrameToken,
	input wire logic        processingHalted
);
	timeunit 1ns;
	timeprecision 1ps;
	logic clrWr;
	assign clrWr = psel && penable && pwrite && paddr == 16'h100c;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_acc(a);
		psel && penable && paddr == a;
	endsequence
	sequence s_wb;
		sharedDonePointerWritten && doneWritebackAllowed ##1 !doneWritebackAllowed;
	endsequence
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_unmapped_err: assert property (s_acc(16'h1040) |-> pslverr)
		else $error("no error on unmapped access");
	a_mapped_ok: assert property (s_acc(16'h1018) |-> !pslverr)
		else $error("error on mapped access");
	a_sof_pair: assert property (sharedFrameWritten && !processingHalted |-> startOfFrameToken)
		else $error("frame start without token");
	a_sof_cause: assert property (startOfFrameToken |-> sharedFrameWritten)
		else $error("token without frame start");
	a_sof_halt: assert property (processingHalted |-> !startOfFrameToken)
		else $error("token sent while halted");
	a_halt_error: assert property (systemError |=> processingHalted)
		else $error("system error did not halt");
	a_halt_sticky: assert property (processingHalted && !clrWr |=> processingHalted)
		else $error("halt dropped without clear");
	a_wb_sets: assert property (sharedDonePointerWritten && doneWritebackAllowed |-> s_wb)
		else $error("writeback did not set status");
	a_wb_sticky: assert property (!doneWritebackAllowed && !clrWr |=> !doneWritebackAllowed)
		else $error("writeback allowed without clear");
endmodule // uhi_irq_ptr_chk

// ---- uhi_core_model.sv ----
// Controller core event source facing the block
module uhi_core_model (
	// Clock
	input wire logic       mclk,
	// Requests from the bench
	input wire logic [7:0] kick,
	// Event pulses, one cycle each
	output logic      [7:0] ev
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge mclk) begin
		ev <= kick;
	end
endmodule // uhi_core_model

// ---- uhi_irq_ptr_tb_top.sv ----
// Self-checking bench for the event and list-pointer block
module uhi_irq_ptr_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, hostIrq;
	logic        frameNumberTop, resumeStateSelected, resumeSignal, processingHalted;
	logic [3:0]  pstrb;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, transferAddr, periodicDescAddr, lfsr;
	logic [7:0]  kick, ev;
	logic        smIrq, smIrqNoPin;
	logic [31:0] commOut, ctrlHeadOut, ctrlCurOut, bulkHeadOut, bulkCurOut, doneOut, expv;
	logic [32:0] expQ[$];
	int          fails, checkCount;
	uhi_core_model far (.mclk, .kick, .ev);
	uhi_irq_ptr uut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .rootHubChange(ev[0]), .frameNumberTop,
		.sharedFrameWritten(ev[1]), .scheduleOverrun(ev[2]), .systemError(ev[3]),
		.resumeStateSelected, .ownershipDone(ev[4]), .transferDone(ev[5]), .transferAddr,
		.sharedDonePointerWritten(ev[6]), .doneWritebackAllowed(), .periodicDescDone(ev[7]),
		.periodicDescAddr, .resumeSignal, .hostIrq, .systemManagementIrq(smIrq),
		.startOfFrameToken(), .processingHalted, .commAreaBase(commOut),
		.controlListHead(ctrlHeadOut), .controlListCurrent(ctrlCurOut),
		.bulkListHead(bulkHeadOut), .bulkListCurrent(bulkCurOut), .lastDoneTransfer(doneOut));
	uhi_irq_ptr #(.HAS_MGMT_PIN(1'b0)) uutNoPin (.mclk, .reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata(), .pready(), .pslverr(), .rootHubChange(ev[0]),
		.frameNumberTop, .sharedFrameWritten(ev[1]), .scheduleOverrun(ev[2]),
		.systemError(ev[3]), .resumeStateSelected, .ownershipDone(ev[4]),
		.transferDone(ev[5]), .transferAddr, .sharedDonePointerWritten(ev[6]),
		.doneWritebackAllowed(), .periodicDescDone(ev[7]), .periodicDescAddr, .resumeSignal,
		.hostIrq(), .systemManagementIrq(smIrqNoPin), .startOfFrameToken(),
		.processingHalted(), .commAreaBase(), .controlListHead(), .controlListCurrent(),
		.bulkListHead(), .bulkListCurrent(), .lastDoneTransfer());
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] ptrPort(input int i);
		case (i)
			0: return commOut;
			2: return ctrlHeadOut;
			3: return ctrlCurOut;
			4: return bulkHeadOut;
			default: return bulkCurOut;
		endcase
	endfunction
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic pulse(input logic [7:0] m);
		@(posedge mclk);
		kick <= m;
		@(posedge mclk);
		kick <= 8'h0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic st(input logic [31:0] e);
		rd(16'h100c, {1'b0, e});
		apb(1'b1, 16'h100c, 32'hffffffff);
	endtask
	task automatic lvl(input logic exp);
		@(negedge mclk);
		cmp({32'h0, hostIrq}, {32'h0, exp});
	endtask
	always @(posedge mclk) begin
		if (psel && penable && !pwrite && pready) cmp({pslverr, prdata}, expQ.pop_front());
	end
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		print_verdict();
	end
	initial begin
		reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hf;
		kick = 0; frameNumberTop = 0; resumeStateSelected = 0; resumeSignal = 0;
		transferAddr = 0; periodicDescAddr = 0; lfsr = 32'h63279f50;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		rd(16'h1010, {1'b0, uhi_pkg::EN_RST});
		for (int i = 0; i < 7; i++) rd(16'h1018 + 16'(4 * i), 33'h0);
		apb(1'b1, 16'h1010, 32'hffffffff);
		rd(16'h1010, {1'b0, uhi_pkg::EN_MASK});
		apb(1'b1, 16'h1014, 32'h00000041);
		rd(16'h1014, 33'h0c000003e);
		$display("Test enables finished");
		pulse(8'h01);
		lvl(1'b0);
		st(32'h40);
		apb(1'b1, 16'h1010, 32'h40);
		pulse(8'h01);
		lvl(1'b1);
		apb(1'b1, 16'h1014, 32'h80000000);
		lvl(1'b0);
		apb(1'b1, 16'h1010, 32'h80000000);
		st(32'h40);
		pulse(8'h08);
		@(negedge mclk);
		cmp({32'h0, processingHalted}, 33'h1);
		pulse(8'h02);
		st(32'h14);
		rd(16'h100c, 33'h0);
		$display("Test events finished");
		for (int i = 1; i <= 4; i++) begin
			pulse(8'h06);
			rd(16'h1008, {1'b0, 14'h0, 2'(i), 16'h0});
			st(32'h05);
		end
		frameNumberTop <= 1'b1;
		pulse(8'h02);
		st(32'h24);
		frameNumberTop <= 1'b0;
		pulse(8'h02);
		st(32'h24);
		transferAddr <= nxt(lfsr);
		pulse(8'h20);
		rd(16'h1030, {1'b0, nxt(lfsr) & uhi_pkg::PTR_MASK});
		cmp({1'b0, doneOut}, {1'b0, nxt(lfsr) & uhi_pkg::PTR_MASK});
		pulse(8'h40);
		rd(16'h1030, 33'h0);
		pulse(8'h60);
		rd(16'h1030, {1'b0, nxt(lfsr) & uhi_pkg::PTR_MASK});
		st(32'h02);
		resumeStateSelected <= 1'b1;
		resumeSignal <= 1'b1;
		repeat (6) @(posedge mclk);
		st(32'h0);
		resumeStateSelected <= 1'b0;
		resumeSignal <= 1'b0;
		repeat (6) @(posedge mclk);
		resumeSignal <= 1'b1;
		repeat (6) @(posedge mclk);
		st(32'h08);
		apb(1'b1, 16'h1008, 32'h08);
		repeat (2) @(negedge mclk);
		cmp({32'h0, smIrq}, 33'h1);
		cmp({32'h0, smIrqNoPin}, 33'h0);
		pulse(8'h10);
		st(32'h40000000);
		@(negedge mclk);
		cmp({32'h0, smIrq}, 33'h0);
		rd(16'h1008, 33'h0);
		$display("Test frames finished");
		lfsr = nxt(nxt(lfsr));
		periodicDescAddr <= lfsr;
		pulse(8'h80);
		for (int i = 0; i < 6; i++) begin
			lfsr = nxt(lfsr);
			apb(1'b1, 16'h1018 + 16'(4 * i), lfsr);
			expv = (i == 1) ? periodicDescAddr : lfsr;
			expv = expv & ((i == 0) ? uhi_pkg::COMM_MASK : uhi_pkg::PTR_MASK);
			rd(16'h1018 + 16'(4 * i), {1'b0, expv});
			@(negedge mclk);
			if (i != 1) cmp({1'b0, ptrPort(i)}, {1'b0, expv});
		end
		apb(1'b1, 16'h1018, 32'hffffffff);
		rd(16'h1018, 33'h0ffffff00);
		pstrb <= 4'h2;
		apb(1'b1, 16'h1018, 32'h0);
		pstrb <= 4'hf;
		rd(16'h1018, 33'h0ffff0000);
		apb(1'b1, 16'h1040, 32'hffffffff);
		rd(16'h1040, 33'h100000000);
		pulse(8'h01);
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		rd(16'h100c, 33'h0);
		rd(16'h1010, {1'b0, uhi_pkg::EN_RST});
		$display("Test pointers finished");
		print_verdict();
	end
endmodule // uhi_irq_ptr_tb_top

bind uhi_irq_ptr uhi_irq_ptr_chk chk (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pready, .pslverr, .sharedFrameWritten, .systemError, .sharedDonePointerWritten,
	.doneWritebackAllowed, .startOfFrameToken, .processingHalted);
